//--- shared/ccd_pkg.sv
// Purpose: constants and types for the frame readout sequencer
// Assumes: core_clk at 250 MHz
// Notes:   gate timing is derived here from nanosecond figures, except the burst gap BLANK_CYC set in ccd_readout

package ccd_pkg;

  // ==========================================================
  // geometry
  localparam int LINES     = 165;
  localparam int IMAGE_PIX = 192;
  localparam int DARK_PIX  = 12;
  localparam int DUMMY_PIX = 6;
  localparam int LINE_PIX  = DUMMY_PIX + IMAGE_PIX + DARK_PIX;
  localparam int ADC_W     = 12;
  localparam int SUM_W     = 16;

  // ==========================================================
  // timing in ns
  localparam int CLK_NS        = 4;
  localparam int T1_NS         = 50;
  localparam int T2_NS         = 50;
  localparam int LTG_HIGH_NS   = 400;
  localparam int LTG_LOW_NS    = 400;
  localparam int TW2_NS        = 350;
  localparam int T3_NS         = 350;
  localparam int T4_NS         = 70;
  localparam int PSG_PERIOD_NS = 100;
  localparam int OVG_PERIOD_NS = 500;

  // minimum times round up to whole cycles
  function automatic logic [15:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return 16'(c);
  endfunction

  localparam logic [15:0] T1_CYC       = ns_to_cyc(T1_NS);
  localparam logic [15:0] T2_CYC       = ns_to_cyc(T2_NS);
  localparam logic [15:0] LTG_HIGH_CYC = ns_to_cyc(LTG_HIGH_NS);
  localparam logic [15:0] LTG_LOW_CYC  = ns_to_cyc(LTG_LOW_NS);
  // line-transfer high spans the transfer pulse rise, so the later 350 ns
  // hold after its fall satisfies both the pulse width and the fall spacing
  localparam logic [15:0] T3_CYC       = ns_to_cyc((T3_NS > TW2_NS) ? T3_NS : TW2_NS);
  localparam logic [15:0] T4_CYC       = ns_to_cyc(T4_NS);
  localparam logic [15:0] PSG_HALF_CYC = ns_to_cyc(PSG_PERIOD_NS / 2);
  localparam logic [15:0] OVG_HALF_CYC = ns_to_cyc(OVG_PERIOD_NS / 2);

  localparam logic [15:0] BURST_PULSES = 16'h0004;

  localparam logic [7:0] LAST_LINE  = 8'(LINES - 1);
  localparam logic [7:0] LAST_PIX   = 8'(LINE_PIX - 1);
  localparam logic [7:0] IMAGE_BASE = 8'(DUMMY_PIX);
  localparam logic [7:0] DARK_BASE  = 8'(DUMMY_PIX + IMAGE_PIX);

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    CLASS_DUMMY,
    CLASS_IMAGE,
    CLASS_DARK
  } ccd_class_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CLR_HIGH,
    ST_CLR_LOW,
    ST_EXP_BURST,
    ST_EXP_GAP,
    ST_RD_SETUP,
    ST_RD_LTG,
    ST_RD_XFER,
    ST_RD_HOLD,
    ST_RD_GAP,
    ST_SH_HIGH,
    ST_SH_LOW
  } ccd_state_type;

endpackage

//--- logic/ccd_fifo.sv
// Purpose: sample buffer between the readout sequencer and its consumer
// Assumes: DEPTH is a power of two
// Notes:   head word sits in its own register so outputs come from flops

`timescale 1ns/100ps

module ccd_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 16
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           count;
    logic                    in_rdy;
    logic                    head_valid;
    logic [W-1:0]            head;
  } ccd_fifo_state_type;

  ccd_fifo_state_type s;
  ccd_fifo_state_type next_s;

  // ==========================================================
  // next state
  always_comb
  begin
    logic push;
    logic take;
    logic [CW-1:0] cnt;
    next_s = s;
    push   = in_valid && s.in_rdy;
    take   = !s.head_valid || out_ready;
    cnt    = s.count;
    if (s.head_valid && out_ready)
    begin
      next_s.head_valid = 1'b0;
    end
    if (take && s.count != '0)
    begin
      next_s.head       = s.mem[s.rptr];
      next_s.head_valid = 1'b1;
      next_s.rptr       = s.rptr + 1'b1;
      cnt               = cnt - 1'b1;
    end
    if (push)
    begin
      next_s.mem[s.wptr] = in_data;
      next_s.wptr        = s.wptr + 1'b1;
      cnt                = cnt + 1'b1;
    end
    next_s.count  = cnt;
    next_s.in_rdy = (cnt < CW'(DEPTH));
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s        <= '0;
      s.in_rdy <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign in_ready  = s.in_rdy;
  assign out_valid = s.head_valid;
  assign out_data  = s.head;

endmodule

//--- logic/ccd_readout.sv
// Purpose: drives the gate clock drivers of a full-frame sensor and tags samples
// Assumes: adc_sample arrives from an external converter, outside core_clk
// Notes:   clear and expose are started by one-cycle command pulses; read starts once a stop_expose request meets scene_dark

`timescale 1ns/100ps

module ccd_readout #(
  parameter int          ADC_W      = ccd_pkg::ADC_W,
  parameter int          FIFO_DEPTH = 16,
  parameter logic [15:0] BLANK_CYC  = 16'h3e03
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      start_clear,
  input  wire logic                      start_expose,
  input  wire logic                      stop_expose,
  input  wire logic                      scene_dark,
  input  wire logic [ADC_W-1:0]          adc_sample,
  output logic                           line_transfer_gate,
  output logic                           pixel_shift_gate,
  output logic                           overflow_gate,
  output logic                           overflow_gate_mid,
  output logic                           busy,
  output logic                           frame_done,
  output logic [ccd_pkg::SUM_W-1:0]      dark_sum,
  output logic                           dark_sum_valid,
  output logic                           pix_valid,
  input  wire logic                      pix_ready,
  output logic [1:0]                     pix_class,
  output logic [ADC_W-1:0]               pix_value
);

  localparam int FW = 2 + ADC_W;

  typedef struct packed {
    ccd_pkg::ccd_state_type     fsm;
    logic [15:0]                cnt;
    logic [15:0]                pulses;
    logic [7:0]                 line;
    logic [7:0]                 pix;
    logic                       ltg;
    logic                       psg;
    logic                       ovg;
    logic                       ovg_mid;
    logic                       stop_req;
    logic                       busy;
    logic                       done;
    logic [ADC_W-1:0]           sync1;
    logic [ADC_W-1:0]           sync2;
    logic [ADC_W-1:0]           sync3;
    logic [ADC_W-1:0]           adc_q;
    logic                       push_valid;
    logic [FW-1:0]              push_data;
    logic [ccd_pkg::SUM_W-1:0]  dark_acc;
    logic [ccd_pkg::SUM_W-1:0]  dark_sum;
    logic                       dark_valid;
  } ccd_rd_state_type;

  ccd_rd_state_type s;
  ccd_rd_state_type next_s;
  logic             fifo_in_ready;
  logic [FW-1:0]    fifo_out;
  logic             fifo_out_valid;

  function automatic logic [1:0] class_of(input logic [7:0] p);
    if (p < ccd_pkg::IMAGE_BASE)
    begin
      return 2'(ccd_pkg::CLASS_DUMMY);
    end
    else if (p < ccd_pkg::DARK_BASE)
    begin
      return 2'(ccd_pkg::CLASS_IMAGE);
    end
    return 2'(ccd_pkg::CLASS_DARK);
  endfunction

  // ==========================================================
  // sequencer
  always_comb
  begin
    logic done_cnt;
    next_s            = s;
    done_cnt          = (s.cnt == 16'h0000);
    next_s.cnt        = done_cnt ? 16'h0000 : s.cnt - 16'h0001;
    next_s.done       = 1'b0;
    next_s.dark_valid = 1'b0;
    // converter pins: a bit changes only when the last two stages agree
    next_s.sync1 = adc_sample;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < ADC_W; i++)
    begin
      if (s.sync2[i] == s.sync3[i])
      begin
        next_s.adc_q[i] = s.sync3[i];
      end
    end
    if (s.push_valid && fifo_in_ready)
    begin
      next_s.push_valid = 1'b0;
    end
    unique case (s.fsm)
      ccd_pkg::ST_IDLE:
      begin
        next_s.ltg      = 1'b0;
        next_s.psg      = 1'b0;
        next_s.ovg      = 1'b0;
        next_s.ovg_mid  = 1'b1;
        next_s.busy     = 1'b0;
        next_s.stop_req = 1'b0;
        next_s.line     = 8'h00;
        if (start_clear)
        begin
          next_s.fsm  = ccd_pkg::ST_CLR_HIGH;
          next_s.ltg  = 1'b1;
          next_s.cnt  = ccd_pkg::LTG_HIGH_CYC - 16'h0001;
          next_s.busy = 1'b1;
        end
        else if (start_expose)
        begin
          next_s.fsm     = ccd_pkg::ST_EXP_BURST;
          next_s.ovg_mid = 1'b0;
          next_s.ovg     = 1'b1;
          next_s.pulses  = ccd_pkg::BURST_PULSES - 16'h0001;
          next_s.cnt     = ccd_pkg::OVG_HALF_CYC - 16'h0001;
          next_s.busy    = 1'b1;
        end
      end
      // shift gate stays low; each transfer dumps a line into the cleared register
      ccd_pkg::ST_CLR_HIGH:
      begin
        if (done_cnt)
        begin
          next_s.ltg = 1'b0;
          next_s.cnt = ccd_pkg::LTG_LOW_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_CLR_LOW;
        end
      end
      ccd_pkg::ST_CLR_LOW:
      begin
        if (done_cnt)
        begin
          if (s.line == ccd_pkg::LAST_LINE)
          begin
            next_s.fsm  = ccd_pkg::ST_IDLE;
            next_s.done = 1'b1;
          end
          else
          begin
            next_s.line = s.line + 8'h01;
            next_s.ltg  = 1'b1;
            next_s.cnt  = ccd_pkg::LTG_HIGH_CYC - 16'h0001;
            next_s.fsm  = ccd_pkg::ST_CLR_HIGH;
          end
        end
      end
      ccd_pkg::ST_EXP_BURST:
      begin
        if (stop_expose)
        begin
          next_s.stop_req = 1'b1;
        end
        if (done_cnt)
        begin
          next_s.cnt = ccd_pkg::OVG_HALF_CYC - 16'h0001;
          if (s.ovg)
          begin
            next_s.ovg = 1'b0;
          end
          else if (s.pulses != 16'h0000)
          begin
            next_s.ovg    = 1'b1;
            next_s.pulses = s.pulses - 16'h0001;
          end
          else
          begin
            next_s.cnt = BLANK_CYC;
            next_s.fsm = ccd_pkg::ST_EXP_GAP;
          end
        end
      end
      // while stopped but still lit the bursts go on, so no pixel blooms
      ccd_pkg::ST_EXP_GAP:
      begin
        if (stop_expose)
        begin
          next_s.stop_req = 1'b1;
        end
        if ((stop_expose || s.stop_req) && scene_dark)
        begin
          next_s.ovg_mid = 1'b1;
          next_s.line    = 8'h00;
          next_s.cnt     = ccd_pkg::T1_CYC - 16'h0001;
          next_s.fsm     = ccd_pkg::ST_RD_SETUP;
        end
        else if (done_cnt)
        begin
          next_s.ovg    = 1'b1;
          next_s.pulses = ccd_pkg::BURST_PULSES - 16'h0001;
          next_s.cnt    = ccd_pkg::OVG_HALF_CYC - 16'h0001;
          next_s.fsm    = ccd_pkg::ST_EXP_BURST;
        end
      end
      ccd_pkg::ST_RD_SETUP:
      begin
        if (done_cnt)
        begin
          next_s.ltg = 1'b1;
          next_s.cnt = ccd_pkg::T2_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_RD_LTG;
        end
      end
      ccd_pkg::ST_RD_LTG:
      begin
        if (done_cnt)
        begin
          next_s.psg = 1'b1;
          next_s.cnt = ccd_pkg::LTG_HIGH_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_RD_XFER;
        end
      end
      ccd_pkg::ST_RD_XFER:
      begin
        if (done_cnt)
        begin
          next_s.ltg = 1'b0;
          next_s.cnt = ccd_pkg::T3_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_RD_HOLD;
        end
      end
      ccd_pkg::ST_RD_HOLD:
      begin
        if (done_cnt)
        begin
          next_s.psg = 1'b0;
          next_s.cnt = ccd_pkg::T4_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_RD_GAP;
        end
      end
      ccd_pkg::ST_RD_GAP:
      begin
        if (done_cnt)
        begin
          next_s.pix      = 8'h00;
          next_s.dark_acc = '0;
          next_s.psg      = 1'b1;
          next_s.cnt      = ccd_pkg::PSG_HALF_CYC - 16'h0001;
          next_s.fsm      = ccd_pkg::ST_SH_HIGH;
        end
      end
      ccd_pkg::ST_SH_HIGH:
      begin
        if (done_cnt)
        begin
          next_s.psg = 1'b0;
          next_s.cnt = ccd_pkg::PSG_HALF_CYC - 16'h0001;
          next_s.fsm = ccd_pkg::ST_SH_LOW;
        end
      end
      // sample late in the low half, after the output has settled;
      // a full buffer stretches the low half instead of losing a pixel
      ccd_pkg::ST_SH_LOW:
      begin
        if (done_cnt && !next_s.push_valid)
        begin
          next_s.push_valid = 1'b1;
          next_s.push_data  = {class_of(s.pix), s.adc_q};
          if (s.pix >= ccd_pkg::DARK_BASE)
          begin
            next_s.dark_acc = s.dark_acc + ccd_pkg::SUM_W'(s.adc_q);
          end
          if (s.pix == ccd_pkg::LAST_PIX)
          begin
            next_s.dark_sum   = s.dark_acc;
            next_s.dark_valid = 1'b1;
            if (s.line == ccd_pkg::LAST_LINE)
            begin
              next_s.fsm  = ccd_pkg::ST_IDLE;
              next_s.done = 1'b1;
            end
            else
            begin
              next_s.line = s.line + 8'h01;
              next_s.cnt  = ccd_pkg::T1_CYC - 16'h0001;
              next_s.fsm  = ccd_pkg::ST_RD_SETUP;
            end
          end
          else
          begin
            next_s.pix = s.pix + 8'h01;
            next_s.psg = 1'b1;
            next_s.cnt = ccd_pkg::PSG_HALF_CYC - 16'h0001;
            next_s.fsm = ccd_pkg::ST_SH_HIGH;
          end
        end
        else if (done_cnt)
        begin
          next_s.cnt = 16'h0000;
        end
      end
    endcase
    if (s.pix >= ccd_pkg::DARK_BASE && s.fsm == ccd_pkg::ST_SH_LOW && next_s.dark_valid)
    begin
      next_s.dark_sum = s.dark_acc + ccd_pkg::SUM_W'(s.adc_q);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s         <= '0;
      s.fsm     <= ccd_pkg::ST_IDLE;
      s.ovg_mid <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================
  // sample buffer
  ccd_fifo #(
    .W     (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (s.push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (s.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (pix_ready),
    .out_data  (fifo_out)
  );

  assign line_transfer_gate = s.ltg;
  assign pixel_shift_gate   = s.psg;
  assign overflow_gate      = s.ovg;
  assign overflow_gate_mid  = s.ovg_mid;
  assign busy               = s.busy;
  assign frame_done         = s.done;
  assign dark_sum           = s.dark_sum;
  assign dark_sum_valid     = s.dark_valid;
  assign pix_valid          = fifo_out_valid;
  assign pix_class          = fifo_out[FW-1 -: 2];
  assign pix_value          = fifo_out[ADC_W-1:0];

endmodule

//--- verif/ccd_readout_sva.sv
// Purpose: gate timing checks for the frame readout sequencer
// Assumes: bound to ccd_readout, one clock domain
// Notes:   run lengths counted in core_clk cycles, saturating
`timescale 1ns/100ps

module ccd_readout_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start_clear,
  input wire logic busy,
  input wire logic scene_dark,
  input wire logic line_transfer_gate,
  input wire logic pixel_shift_gate,
  input wire logic overflow_gate,
  input wire logic overflow_gate_mid
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // run lengths; low runs start saturated so reset counts as long ago
  logic [15:0] ltg_hi;
  logic [15:0] ltg_lo;
  logic [15:0] psg_hi;
  logic [15:0] psg_lo;
  logic [15:0] og_hi;
  logic        xfer;

  function automatic logic [15:0] step(input logic lvl, input logic [15:0] c);
    return lvl ? ((c == 16'hffff) ? c : c + 16'h0001) : 16'h0000;
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ltg_hi <= 16'h0000;
      ltg_lo <= 16'hffff;
      psg_hi <= 16'h0000;
      psg_lo <= 16'hffff;
      og_hi  <= 16'h0000;
      xfer   <= 1'b0;
    end
    else
    begin
      ltg_hi <= step(line_transfer_gate, ltg_hi);
      ltg_lo <= step(!line_transfer_gate, ltg_lo);
      psg_hi <= step(pixel_shift_gate, psg_hi);
      psg_lo <= step(!pixel_shift_gate, psg_lo);
      og_hi  <= step(overflow_gate, og_hi);
      xfer   <= pixel_shift_gate & (xfer | line_transfer_gate);
    end
  end

  // ==========================================================
  // properties
  property p_clear_go;
    start_clear && !busy |=> busy && line_transfer_gate;
  endproperty
  a_clear_go: assert property (p_clear_go) else $error("clear start not answered");

  property p_ltg_setup;
    $rose(line_transfer_gate) |-> psg_lo >= ccd_pkg::T1_CYC;
  endproperty
  a_ltg_setup: assert property (p_ltg_setup) else $error("line gate rose early");

  property p_xfer_setup;
    $rose(pixel_shift_gate) && line_transfer_gate |-> ltg_hi >= ccd_pkg::T2_CYC;
  endproperty
  a_xfer_setup: assert property (p_xfer_setup) else $error("transfer pulse rose early");

  property p_xfer_width;
    $fell(pixel_shift_gate) && xfer |-> psg_hi >= ccd_pkg::T3_CYC;
  endproperty
  a_xfer_width: assert property (p_xfer_width) else $error("transfer pulse too short");

  property p_xfer_hold;
    $fell(pixel_shift_gate) && xfer |-> ltg_lo >= ccd_pkg::T3_CYC;
  endproperty
  a_xfer_hold: assert property (p_xfer_hold) else $error("transfer pulse fell early");

  property p_first_shift;
    $fell(pixel_shift_gate) && xfer |-> ##1 !pixel_shift_gate[*8] ##1 !pixel_shift_gate[*8]
      ##1 !pixel_shift_gate;
  endproperty
  a_first_shift: assert property (p_first_shift) else $error("first shift too soon");

  property p_shift_high;
    $fell(pixel_shift_gate) && !xfer |-> psg_hi >= ccd_pkg::PSG_HALF_CYC;
  endproperty
  a_shift_high: assert property (p_shift_high) else $error("shift pulse too short");

  property p_shift_low;
    $fell(pixel_shift_gate) && !xfer |-> !pixel_shift_gate[*8] ##1 !pixel_shift_gate[*5];
  endproperty
  a_shift_low: assert property (p_shift_low) else $error("shift low too short");

  property p_og_high;
    $fell(overflow_gate) |-> og_hi >= ccd_pkg::OVG_HALF_CYC;
  endproperty
  a_og_high: assert property (p_og_high) else $error("overflow pulse too short");

  property p_og_steady;
    overflow_gate_mid |-> !overflow_gate;
  endproperty
  a_og_steady: assert property (p_og_steady) else $error("overflow pulsed in readout");

  property p_dark_start;
    $rose(overflow_gate_mid) |-> $past(scene_dark);
  endproperty
  a_dark_start: assert property (p_dark_start) else $error("readout began while lit");

  c_clear: cover property (start_clear && !busy);
  c_xfer: cover property ($fell(pixel_shift_gate) && xfer);
  c_burst: cover property ($rose(overflow_gate));
endmodule

//--- verif/ccd_sensor_model.sv
// Purpose: behavioural sensor: image lines into a serial register, out on shift falls
// Assumes: gate levels as ccd_readout drives them
// Notes:   no reset, as the sensor has none; dummy cells start at 0aa
`timescale 1ns/100ps

module ccd_sensor_model (
  input  wire logic                      line_transfer_gate,
  input  wire logic                      pixel_shift_gate,
  output logic [ccd_pkg::ADC_W-1:0]      adc_sample
);
  // ==========================================================
  // serial register, dummy cells at the output end (index 0)
  logic [11:0] sr [0:ccd_pkg::LINE_PIX-1];
  logic [7:0]  lines;
  logic        xfer;

  initial
  begin
    for (int i = 0; i < ccd_pkg::LINE_PIX; i++)
      sr[i] = 12'h0aa;
    lines = 8'h00;
    xfer = 1'b0;
    adc_sample = 12'h000;
  end

  always @(posedge line_transfer_gate)
  begin
    lines = lines + 8'h01;
    for (int i = ccd_pkg::DUMMY_PIX; i < ccd_pkg::LINE_PIX; i++)
      sr[i] = 12'h000;
    for (int p = 0; p < ccd_pkg::IMAGE_PIX; p++)
      sr[ccd_pkg::DUMMY_PIX + p] = {lines[3:0], 8'(p)};
    for (int d = 0; d < ccd_pkg::DARK_PIX; d++)
      sr[ccd_pkg::DUMMY_PIX + ccd_pkg::IMAGE_PIX + d] = 12'hf00 | 12'(d);
  end

  // rise while line gate is high is the transfer pulse, not a shift
  always @(posedge pixel_shift_gate)
  begin
    xfer = line_transfer_gate;
    #8 adc_sample = ~adc_sample;
  end

  always @(negedge pixel_shift_gate)
  begin
    if (xfer)
      xfer = 1'b0;
    else
    begin
      #25 adc_sample = sr[0];
      for (int i = 0; i < ccd_pkg::LINE_PIX - 1; i++)
        sr[i] = sr[i + 1];
      sr[ccd_pkg::LINE_PIX - 1] = 12'h055;
    end
  end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the frame readout sequencer
// Assumes: sensor model on the far side, blanking shortened to 16 cycles
// Notes:   a whole frame is too long; one line is read, then reset mid-run
`timescale 1ns/100ps

module tb;
  logic        core_clk;
  logic        rst;
  logic        start_clear;
  logic        start_expose;
  logic        stop_expose;
  logic        scene_dark;
  logic        pix_ready;
  logic [11:0] adc_sample;
  logic        line_transfer_gate;
  logic        pixel_shift_gate;
  logic        overflow_gate;
  logic        overflow_gate_mid;
  logic        busy;
  logic        frame_done;
  logic [15:0] dark_sum;
  logic        dark_sum_valid;
  logic        pix_valid;
  logic [1:0]  pix_class;
  logic [11:0] pix_value;
  logic [15:0] last_dark;
  logic [13:0] words [$];
  int          n_mismatch;
  int          n_checks;

  ccd_readout #(.BLANK_CYC(16'h0010)) dut (.core_clk, .rst, .start_clear, .start_expose,
    .stop_expose, .scene_dark, .adc_sample, .line_transfer_gate, .pixel_shift_gate,
    .overflow_gate, .overflow_gate_mid, .busy, .frame_done, .dark_sum, .dark_sum_valid,
    .pix_valid, .pix_ready, .pix_class, .pix_value);
  ccd_sensor_model sensor (.line_transfer_gate, .pixel_shift_gate, .adc_sample);

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (!rst && pix_valid === 1'b1 && pix_ready === 1'b1)
      words.push_back({pix_class, pix_value});
    if (!rst && dark_sum_valid === 1'b1)
      last_dark = dark_sum;
  end

  // ==========================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rst = 1'b1;
    repeat (3)
      @(negedge core_clk);
    rst = 1'b0;
    check("reset outputs", 16'h0008, {9'h0, line_transfer_gate, pixel_shift_gate,
      overflow_gate, overflow_gate_mid, busy, frame_done, pix_valid});
  endtask

  task automatic t_clear;
    int r;
    int bad;
    int c;
    logic p;
    r = 0;
    bad = 0;
    c = 0;
    p = 1'b0;
    @(negedge core_clk);
    start_clear = 1'b1;
    @(negedge core_clk);
    start_clear = 1'b0;
    start_expose = 1'b1;
    @(negedge core_clk);
    start_expose = 1'b0;
    while (frame_done !== 1'b1 && c < 40000)
    begin
      r += int'(line_transfer_gate && !p);
      bad += int'(pixel_shift_gate | overflow_gate);
      p = line_transfer_gate;
      c++;
      @(negedge core_clk);
    end
    check("clear transfers", 16'(ccd_pkg::LINES), 16'(r));
    check("shift held in clear", 16'h0000, 16'(bad));
    repeat (4)
      @(negedge core_clk);
  endtask

  task automatic t_expose;
    int r;
    int bad;
    logic p;
    r = 0;
    bad = 0;
    p = 1'b0;
    scene_dark = 1'b0;
    pix_ready = 1'b0;
    @(negedge core_clk);
    start_expose = 1'b1;
    @(negedge core_clk);
    start_expose = 1'b0;
    repeat (2 * ccd_pkg::OVG_HALF_CYC * ccd_pkg::BURST_PULSES + 8)
    begin
      r += int'(overflow_gate && !p);
      p = overflow_gate;
      @(negedge core_clk);
    end
    check("burst pulses", ccd_pkg::BURST_PULSES, 16'(r));
    stop_expose = 1'b1;
    r = 0;
    repeat (700)
    begin
      r += int'(overflow_gate && !p);
      bad += int'(line_transfer_gate | overflow_gate_mid);
      p = overflow_gate;
      @(negedge core_clk);
    end
    check("lit hold", 16'h0000, 16'(bad));
    check("bursts go on", 16'h0001, 16'(r != 0));
    scene_dark = 1'b1;
    r = 0;
    while (line_transfer_gate !== 1'b1 && r < 800)
    begin
      r++;
      @(negedge core_clk);
    end
    stop_expose = 1'b0;
    check("transfer in dark", 16'h0001, {15'h0, line_transfer_gate});
    check("overflow held", 16'h0001, {15'h0, overflow_gate_mid & !overflow_gate});
  endtask

  task automatic t_line;
    int f;
    logic p;
    logic [13:0] e;
    logic [15:0] sum;
    f = 0;
    p = 1'b0;
    sum = 16'h0000;
    repeat (800)
      @(negedge core_clk);
    // full buffer must stop the shift clock, not drop samples
    repeat (200)
    begin
      f += int'(p && !pixel_shift_gate);
      p = pixel_shift_gate;
      @(negedge core_clk);
    end
    check("stalled shifts", 16'h0000, 16'(f));
    check("head waiting", 16'h0001, {15'h0, pix_valid});
    pix_ready = 1'b1;
    f = 0;
    while (words.size() < ccd_pkg::LINE_PIX && f < 8000)
    begin
      f++;
      @(negedge core_clk);
    end
    repeat (50)
      @(negedge core_clk);
    check("line words", 16'(ccd_pkg::LINE_PIX), 16'(words.size()));
    for (int k = 0; k < ccd_pkg::LINE_PIX && words.size() > 0; k++)
    begin
      if (k < ccd_pkg::DUMMY_PIX)
        e = {2'(ccd_pkg::CLASS_DUMMY), 12'h0aa};
      else if (k < ccd_pkg::DARK_BASE)
        e = {2'(ccd_pkg::CLASS_IMAGE), 4'(ccd_pkg::LINES + 1), 8'(k - ccd_pkg::DUMMY_PIX)};
      else
        e = {2'(ccd_pkg::CLASS_DARK), 12'hf00 | 12'(k - ccd_pkg::DARK_BASE)};
      check("sample", {2'h0, e}, {2'h0, words.pop_front()});
    end
    for (int d = 0; d < ccd_pkg::DARK_PIX; d++)
      sum = sum + (16'h0f00 | 16'(d));
    check("dark sum", sum, last_dark);
  endtask

  initial
  begin
    rst = 1'b1;
    start_clear = 1'b0;
    start_expose = 1'b0;
    stop_expose = 1'b0;
    scene_dark = 1'b1;
    pix_ready = 1'b1;
    last_dark = 'x;
    n_mismatch = 0;
    n_checks = 0;
    t_reset;
    t_clear;
    t_expose;
    t_line;
    t_reset;
    results;
  end

  initial
  begin
    repeat (90000)
      @(posedge core_clk);
    n_mismatch++;
    results;
  end
endmodule

bind ccd_readout ccd_readout_sva sva (.core_clk, .rst, .start_clear, .busy, .scene_dark,
  .line_transfer_gate, .pixel_shift_gate, .overflow_gate, .overflow_gate_mid);
